/* hw/ctw_cap_trim.sv */
// capacitor trim command interpreter, reference-clock side
//
// Summary of operation
// R1 - stored-code writes keep the operating mode and work in either mode
// R2 - stored code is written one nibble per command, erase before write
// R3 - command byte one with top bit set targets stored code
// R4 - nibble address comes from command byte one bits 6 and 5
// R5 - bit 4 must be clear for a stored write; low nibble ignored
// R6 - nibble 2 takes code bit 8, 1 bits 7:4, 0 bits 3:0
// R7 - erase is a stored write whose data nibble is zero
// R8 - nibbles are independent; unwritten nibbles keep their value
// R9 - programming runs from after the second byte until the stop
// R10 - master sends zero fillers or holds the clock low meanwhile
// R11 - new stored value reaches the control register only on a read
// R12 - in volatile mode master must also switch mode after the read
// R13 - after erase no read needed unless the final value is zero
// R14 - a read returns four bytes, byte 3 first down to byte 0
// R15 - byte 3: 0x8, mode, last nibble address, volatile bit 8
// R16 - byte 2 carries volatile code bits 7 to 0
// R17 - byte 1: zero nibble, address select, fixed 2, stored bit 8
// R18 - byte 0 carries stored code bits 7 to 0
// R19 - every read copies stored code into the stored-mode control register
// R20 - readback shows the data most recently written to each store
// R21 - volatile register clears at power-up
// R22 - switching back to stored mode keeps the volatile register value
// R23 - master sets the address low bit to pick the variant
// R24 - a volatile write switches to volatile mode until reset or switch
// R25 - command byte one upper nibble 9 selects stored mode
// R26 - master holds each programming interval for its nominal time; the bench master shortens it
// R27 - every received byte is acknowledged with a low
// R28 - a stored write to nibble address 3 changes nothing; the code still records 3 as the last nibble address
`timescale 1ns/1ps
`include "ctw_consts.svh"
module ctw_cap_trim
  import ctw_pkg::*;
#(
  parameter logic [5:0] ADDR_HI  = 6'h2A,  // arbitrary value
  parameter logic       ADDR_SEL = 1'b0,
  parameter logic [8:0] NV_INIT  = 9'h000
) (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // serial link
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // capacitor control and status
  output logic [8:0]      capacitor_code,
  output logic            mode_nv,
  output logic            prog_busy,
  output logic [1:0]      last_nibble_address
);
  // synchronised pins and link events
  logic [3:0] sync_w;
  logic       scl_s;
  logic       sda_s;
  logic       rxt_s;
  logic       rdt_s;
  logic       sda_q_ff;
  logic       scl_q_ff;
  logic       rxt_q_ff;
  logic       rdt_q_ff;
  logic       start_w;
  logic       stop_w;
  logic       rx_ev;
  logic       rd_ev;
  // frame tracking
  logic       bus_ff;
  logic [3:0] clr_cnt_ff;
  logic       link_clr_ff;
  logic [1:0] wcnt_ff;
  logic [7:0] cfg1_ff;
  logic       exec_w;
  ctw_cmd_t   cmd_w;
  // link side
  logic [7:0] rx_byte_w;
  logic       rx_tgl_w;
  logic       rd_tgl_w;
  logic       link_oe_w;
  // device state
  logic [8:0]  vr_ff;
  logic        mode_ff;
  logic [8:0]  nv_ff;
  logic [8:0]  nvctl_ff;
  logic [1:0]  last_ff;
  logic        pend_ff;
  logic [1:0]  paddr_ff;
  logic [3:0]  pnib_ff;
  logic [8:0]  cap_ff;
  logic [31:0] rb_ff;
  logic        sda_out_ff;

  ctw_sync #(
    .W (4)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (nrst),
    .en    (ce),
    .d     ({scl, sda_in, rx_tgl_w, rd_tgl_w}),
    .q     (sync_w)
  );

  assign scl_s = sync_w[3];
  assign sda_s = sync_w[2];
  assign rxt_s = sync_w[1];
  assign rdt_s = sync_w[0];

  ctw_link #(
    .ADDR_HI  (ADDR_HI),
    .ADDR_SEL (ADDR_SEL)
  ) u_link (
    .scl      (scl),
    .nrst     (nrst),
    .link_clr (link_clr_ff),
    .sda_in   (sda_in),
    .sda_oe   (link_oe_w),
    .rb_word  (rb_ff),
    .rx_byte  (rx_byte_w),
    .rx_tgl   (rx_tgl_w),
    .rd_tgl   (rd_tgl_w)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sda_q_ff <= 1'b1;
      scl_q_ff <= 1'b0;
      rxt_q_ff <= 1'b0;
      rdt_q_ff <= 1'b0;
    end else if (ce) begin
      sda_q_ff <= sda_s;
      scl_q_ff <= scl_s;
      rxt_q_ff <= rxt_s;
      rdt_q_ff <= rdt_s;
    end
  end

  // scl must be seen high twice: the synchroniser leaves reset low,
  // and its first high sample would otherwise look like a stop
  assign start_w = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_w  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign rx_ev   = rxt_s ^ rxt_q_ff;
  assign rd_ev   = rdt_s ^ rdt_q_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) bus_ff <= 1'b0;
    else if (ce) begin
      if (start_w) bus_ff <= 1'b1;
      else if (stop_w) bus_ff <= 1'b0;
    end
  end

  // short clear of the link logic at every start; scl stays high
  // for the whole pulse, so no link edge races the release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clr_cnt_ff  <= 4'h0;
      link_clr_ff <= 1'b0;
    end else if (ce) begin
      if (start_w) begin
        clr_cnt_ff  <= 4'(`CTW_CLR_CYC);
        link_clr_ff <= 1'b1;
      end else if (clr_cnt_ff != 4'h0) begin
        clr_cnt_ff  <= clr_cnt_ff - 4'h1;
        link_clr_ff <= (clr_cnt_ff != 4'h1);
      end
    end
  end

  // only the first two written bytes count; fillers are dropped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wcnt_ff <= 2'h0;
      cfg1_ff <= 8'h00;
    end else if (ce) begin
      if (start_w) wcnt_ff <= 2'h0;
      else if (rx_ev && wcnt_ff != `CTW_WR_BYTES) begin
        wcnt_ff <= wcnt_ff + 2'h1;
        if (wcnt_ff == 2'h0) cfg1_ff <= rx_byte_w;
      end
    end
  end

  // rx_byte_w is held for a whole byte time after its toggle
  assign exec_w = ce & rx_ev & (wcnt_ff == 2'h1);
  assign cmd_w  = ctw_cmd_of(cfg1_ff); // R3 R5

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) vr_ff <= `CTW_VR_RST; // R21
    else if (exec_w && cmd_w == ctw_cmd_vol)
      vr_ff <= {cfg1_ff[`CTW_VR_MSB_BIT], rx_byte_w}; // R20
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) mode_ff <= `CTW_MODE_RST;
    else if (exec_w) begin
      case (cmd_w)
        ctw_cmd_vol:   mode_ff <= 1'b0; // R24
        ctw_cmd_setnv: mode_ff <= 1'b1; // R25 R22
        default:       mode_ff <= mode_ff; // R1
      endcase
    end
  end

  // nibble is latched at the second byte, programmed until the stop
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff  <= 1'b0;
      paddr_ff <= 2'h0;
      pnib_ff  <= 4'h0;
      last_ff  <= 2'h0;
    end else if (exec_w && cmd_w == ctw_cmd_nvw) begin
      pend_ff  <= 1'b1; // R9
      paddr_ff <= cfg1_ff[`CTW_NADDR_HI:`CTW_NADDR_LO]; // R4
      pnib_ff  <= rx_byte_w[3:0]; // R7
      last_ff  <= cfg1_ff[`CTW_NADDR_HI:`CTW_NADDR_LO];
    end else if (ce && (stop_w || start_w)) begin
      pend_ff <= 1'b0; // R9
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) nv_ff <= NV_INIT;
    else if (ce && stop_w && pend_ff)
      nv_ff <= ctw_nib_write(nv_ff, paddr_ff, pnib_ff); // R2 R6 R8 R28
  end

  // stored value reaches the capacitor path only through a read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) nvctl_ff <= NV_INIT;
    else if (ce && rd_ev) nvctl_ff <= nv_ff; // R11 R19
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cap_ff <= NV_INIT;
    else if (ce) cap_ff <= mode_ff ? nvctl_ff : vr_ff; // R24
  end

  // frozen while the bus is busy so the link reads a stable word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rb_ff <= 32'h0000_0000;
    else if (ce && !bus_ff) begin
      rb_ff <= {`CTW_RB3_TAG, mode_ff, last_ff,
                vr_ff[`CTW_CODE_MSB], // R15
                vr_ff[7:0], // R16
                `CTW_RB1_TAG, ADDR_SEL, `CTW_RB1_FIX,
                nv_ff[`CTW_CODE_MSB], // R17
                nv_ff[7:0]}; // R18 R20
    end
  end

  // the data line output level is always low; only the enable moves
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) sda_out_ff <= 1'b0;
    else if (ce) sda_out_ff <= 1'b0;
  end

  assign sda_out             = sda_out_ff;
  assign sda_oe              = link_oe_w;
  assign capacitor_code      = cap_ff;
  assign mode_nv             = mode_ff;
  assign prog_busy           = pend_ff;
  assign last_nibble_address = last_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_vol_mode_set: assert property ( // R24
    exec_w && cmd_w == ctw_cmd_vol |=> !mode_ff)
    else $error("volatile write did not select volatile mode");

  a_setnv_mode: assert property ( // R25 R22
    exec_w && cmd_w == ctw_cmd_setnv |=> mode_ff && $stable(vr_ff))
    else $error("mode switch failed or disturbed volatile code");

  a_nvw_keep_mode: assert property ( // R1
    exec_w && cmd_w == ctw_cmd_nvw |=> $stable(mode_ff))
    else $error("stored write changed the mode");

  a_vr_load: assert property ( // R20
    exec_w && cmd_w == ctw_cmd_vol
      |=> vr_ff == {$past(cfg1_ff[0]), $past(rx_byte_w)})
    else $error("volatile code not loaded from the command");

  a_nib_commit: assert property ( // R6
    ce && stop_w && pend_ff && paddr_ff == `CTW_NIB_CODE74
      |=> nv_ff[7:4] == $past(pnib_ff) && nv_ff[8] == $past(nv_ff[8])
          && nv_ff[3:0] == $past(nv_ff[3:0]))
    else $error("middle nibble not written alone");

  a_nib_low: assert property ( // R6 R8
    ce && stop_w && pend_ff && paddr_ff == `CTW_NIB_CODE30
      |=> nv_ff[3:0] == $past(pnib_ff)
          && nv_ff[8:4] == $past(nv_ff[8:4]))
    else $error("low nibble not written alone");

  a_nib_msb: assert property ( // R6
    ce && stop_w && pend_ff && paddr_ff == `CTW_NIB_CODE8
      |=> nv_ff[8] == $past(pnib_ff[0])
          && nv_ff[7:0] == $past(nv_ff[7:0]))
    else $error("code bit 8 not written alone");

  a_addr3_keep: assert property ( // R28
    ce && stop_w && pend_ff && paddr_ff == 2'h3 |=> $stable(nv_ff))
    else $error("nibble address 3 altered stored code");

  a_last_addr: assert property ( // R4
    exec_w && cmd_w == ctw_cmd_nvw
      |=> last_ff == $past(cfg1_ff[`CTW_NADDR_HI:`CTW_NADDR_LO]))
    else $error("last nibble address not taken from the command");

  a_busy_hold: assert property ( // R9
    pend_ff && !stop_w && !start_w |=> pend_ff)
    else $error("programming ended before the stop");

  a_busy_end: assert property ( // R9
    ce && stop_w |=> !pend_ff)
    else $error("programming continued past the stop");

  a_start_drop: assert property ( // R9
    ce && start_w && !exec_w |=> !pend_ff)
    else $error("new start did not drop the pending write");

  a_none_ignored: assert property ( // R25
    exec_w && cmd_w == ctw_cmd_none
      |=> $stable(mode_ff) && $stable(vr_ff))
    else $error("ignored command changed mode or volatile code");

  a_read_copy: assert property ( // R19
    ce && rd_ev |=> nvctl_ff == $past(nv_ff))
    else $error("read did not load the control register");

  a_ctl_only_read: assert property ( // R11
    !(ce && rd_ev) |=> $stable(nvctl_ff))
    else $error("control register moved without a read");

  a_rb_layout: assert property ( // R15 R17
    ce && !bus_ff |=> rb_ff[31:28] == `CTW_RB3_TAG
      && rb_ff[15:12] == `CTW_RB1_TAG
      && rb_ff[10:9] == `CTW_RB1_FIX && rb_ff[27] == $past(mode_ff))
    else $error("readback word layout wrong");

  a_rb_codes: assert property ( // R16 R18
    ce && !bus_ff |=> rb_ff[24:16] == $past(vr_ff)
      && rb_ff[8:0] == $past(nv_ff))
    else $error("readback codes differ from the stored values");

  a_cap_select: assert property ( // R24
    ce ##1 ce && $stable(mode_ff) && !mode_ff
      |=> capacitor_code == $past(vr_ff))
    else $error("capacitor code not taken from volatile code");

  c_start_drop: cover property (ce && start_w && pend_ff);
  c_vol_write: cover property (exec_w && cmd_w == ctw_cmd_vol);
  c_nv_commit: cover property (ce && stop_w && pend_ff);
  c_read_evt:  cover property (ce && rd_ev);
  c_set_nv:    cover property (exec_w && cmd_w == ctw_cmd_setnv);
endmodule // ctw_cap_trim

/* hw/ctw_consts.svh */
// constants for the capacitor trim command interpreter
`ifndef CTW_CONSTS_SVH
`define CTW_CONSTS_SVH
`define CTW_NV_BIT        7
`define CTW_NADDR_HI      6
`define CTW_NADDR_LO      5
`define CTW_SETNV_BIT     4
`define CTW_VR_MSB_BIT    0
`define CTW_SETNV_NIB     4'h9
`define CTW_CODE_MSB      8
`define CTW_NIB_CODE8     2'h2
`define CTW_NIB_CODE74    2'h1
`define CTW_NIB_CODE30    2'h0
`define CTW_RB3_TAG       4'h8
`define CTW_RB1_TAG       4'h0
`define CTW_RB1_FIX       2'h2
`define CTW_ACK_BIT       4'h8
`define CTW_LAST_DATA_BIT 4'h7
`define CTW_LAST_BYTE     2'h3
`define CTW_WR_BYTES      2'h2
`define CTW_MODE_RST      1'b1
`define CTW_VR_RST        9'h000
`define CTW_REF_PERIOD_PS 5000
`define CTW_CLR_PULSE_NS  50
`define CTW_CLR_CYC ((`CTW_CLR_PULSE_NS * 1000 + `CTW_REF_PERIOD_PS - 1) / `CTW_REF_PERIOD_PS)
`endif

/* hw/ctw_pkg.sv */
// types and shared decode functions of the capacitor trim block
`include "ctw_consts.svh"
package ctw_pkg;
  typedef enum logic [1:0] {
    ctw_lk_addr, ctw_lk_write, ctw_lk_read, ctw_lk_skip
  } ctw_lk_st_t;
  typedef enum logic [1:0] {
    ctw_cmd_vol, ctw_cmd_setnv, ctw_cmd_nvw, ctw_cmd_none
  } ctw_cmd_t;

  function automatic ctw_cmd_t ctw_cmd_of(input logic [7:0] c1);
    ctw_cmd_t r;
    if (!c1[`CTW_NV_BIT]) r = ctw_cmd_vol;
    else if (c1[7:4] == `CTW_SETNV_NIB) r = ctw_cmd_setnv;
    else if (!c1[`CTW_SETNV_BIT]) r = ctw_cmd_nvw;
    else r = ctw_cmd_none;
    return r;
  endfunction

  function automatic logic [8:0] ctw_nib_write(input logic [8:0] nv,
      input logic [1:0] a, input logic [3:0] d);
    logic [8:0] r;
    r = nv;
    case (a)
      `CTW_NIB_CODE8:  r[`CTW_CODE_MSB] = d[0];
      `CTW_NIB_CODE74: r[7:4] = d;
      `CTW_NIB_CODE30: r[3:0] = d;
      default:         r = nv;
    endcase
    return r;
  endfunction
endpackage

/* hw/ctw_sync.sv */
// two-flop synchroniser for a group of single-bit levels
`timescale 1ns/1ps
module ctw_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (en) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // ctw_sync

/* hw/ctw_link.sv */
// serial-clock side: byte shifter, acknowledge and readback driver
`timescale 1ns/1ps
`include "ctw_consts.svh"
module ctw_link
  import ctw_pkg::*;
#(
  parameter logic [5:0] ADDR_HI  = 6'h2A,  // arbitrary value
  parameter logic       ADDR_SEL = 1'b0
) (
  // link clock and resets
  input  wire logic        scl,
  input  wire logic        nrst,
  input  wire logic        link_clr,
  // data pin
  input  wire logic        sda_in,
  output logic             sda_oe,
  // readback word, frozen while the bus is busy
  input  wire logic [31:0] rb_word,
  // events toward the reference domain
  output logic [7:0]       rx_byte,
  output logic             rx_tgl,
  output logic             rd_tgl
);
  // frame logic is cleared at every start; toggles keep nrst only
  logic       lrst_n;
  logic [3:0] bit_ff;
  logic [6:0] sh_ff;
  ctw_lk_st_t st_ff;
  logic       ack_ff;
  logic [1:0] idx_ff;
  logic [7:0] rx_ff;
  logic       rxt_ff;
  logic       rdt_ff;
  logic       oe_ff;
  logic [7:0] byte_w;
  logic       done_w;
  logic       match_w;
  logic [7:0] tx_byte;
  logic       nxt_oe;

  assign lrst_n  = nrst & ~link_clr;
  assign byte_w  = {sh_ff, sda_in};
  assign done_w  = (bit_ff == `CTW_LAST_DATA_BIT);
  assign match_w = (byte_w[7:1] == {ADDR_HI, ADDR_SEL}); // R23

  always_ff @(posedge scl or negedge lrst_n) begin
    if (!lrst_n) bit_ff <= 4'h0;
    else if (bit_ff == `CTW_ACK_BIT) bit_ff <= 4'h0;
    else bit_ff <= bit_ff + 4'h1;
  end

  always_ff @(posedge scl or negedge lrst_n) begin
    if (!lrst_n) sh_ff <= 7'h00;
    else if (bit_ff != `CTW_ACK_BIT) sh_ff <= byte_w[6:0];
  end

  always_ff @(posedge scl or negedge lrst_n) begin
    if (!lrst_n) begin
      st_ff  <= ctw_lk_addr;
      ack_ff <= 1'b0;
      idx_ff <= 2'h0;
    end else if (done_w) begin
      ack_ff <= (st_ff == ctw_lk_write) ||
                (st_ff == ctw_lk_addr && match_w); // R27
      case (st_ff)
        ctw_lk_addr: st_ff <= !match_w ? ctw_lk_skip :
                              byte_w[0] ? ctw_lk_read : ctw_lk_write;
        default:     st_ff <= st_ff;
      endcase
    end else if (bit_ff == `CTW_ACK_BIT) begin
      ack_ff <= 1'b0;
      // master nack or fourth byte ends the readback
      if (st_ff == ctw_lk_read && !ack_ff) begin
        idx_ff <= idx_ff + 2'h1; // R14
        if (sda_in || idx_ff == `CTW_LAST_BYTE) st_ff <= ctw_lk_skip;
      end
    end
  end

  always_ff @(posedge scl or negedge nrst) begin
    if (!nrst) begin
      rx_ff  <= 8'h00;
      rxt_ff <= 1'b0;
      rdt_ff <= 1'b0;
    end else if (done_w) begin
      if (st_ff == ctw_lk_write) begin
        rx_ff  <= byte_w;
        rxt_ff <= ~rxt_ff;
      end
      if (st_ff == ctw_lk_addr && match_w && byte_w[0]) rdt_ff <= ~rdt_ff;
    end
  end

  // byte 3 goes out first, byte 0 last
  always_comb begin
    case (idx_ff)
      2'h0:    tx_byte = rb_word[31:24]; // R14
      2'h1:    tx_byte = rb_word[23:16];
      2'h2:    tx_byte = rb_word[15:8];
      default: tx_byte = rb_word[7:0];
    endcase
    if (bit_ff == `CTW_ACK_BIT) nxt_oe = ack_ff; // R27
    else nxt_oe = (st_ff == ctw_lk_read) && !tx_byte[~bit_ff[2:0]];
  end

  // open drain: drive only lows, change only while scl is low
  always_ff @(negedge scl or negedge lrst_n) begin
    if (!lrst_n) oe_ff <= 1'b0;
    else oe_ff <= nxt_oe;
  end

  assign sda_oe  = oe_ff;
  assign rx_byte = rx_ff;
  assign rx_tgl  = rxt_ff;
  assign rd_tgl  = rdt_ff;
endmodule // ctw_link

/* dv/ctw_bus_master.sv */
// serial bus master model that drives the capacitor trim link
`timescale 1ns/1ps
module ctw_bus_master #(
  parameter logic [6:0] DEV = 7'h2B  // arbitrary value, low bit picks variant
) (
  // serial link, open drain
  output logic      scl,
  output logic      sda_low,
  // resolved data wire
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data changes only a little after the clock has fallen
  task automatic put(input logic b);
    #3 sda_low = ~b;
    #12 scl = 1'b1;
    #15 scl = 1'b0;
  endtask

  task automatic get(output logic b);
    #3 sda_low = 1'b0;
    #12 scl = 1'b1;
    #7 b = sda;
    #8 scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, inout logic nak);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    nak = nak | a;
  endtask

  // start hold is long enough to cover the link clear
  task automatic open(input logic [6:0] dev, input logic rw,
      output logic nak);
    nak = 1'b0;
    sda_low = 1'b1;
    #120 scl = 1'b0;
    wbyte({dev, rw}, nak);
  endtask

  // only the stop commits programming; a start drops it
  task automatic close();
    #3 sda_low = 1'b1;
    #12 scl = 1'b1;
    #120 sda_low = 1'b0;
    #1400;
  endtask

  // zero fillers, then clock held low; interval shortened
  task automatic wcmd(input logic [7:0] c1, c0, input int fill,
      output logic nak);
    open(DEV, 1'b0, nak);
    wbyte(c1, nak);
    wbyte(c0, nak);
    repeat (fill) wbyte(8'h00, nak);
    #300;
  endtask

  // master acks every byte but the last
  task automatic rd(output logic [31:0] w, output logic nak);
    logic [7:0] b;
    open(DEV, 1'b1, nak);
    for (int i = 3; i >= 0; i--) begin
      for (int j = 7; j >= 0; j--) get(b[j]);
      put(i == 0);
      w = {w[23:0], b};
    end
    close();
  endtask
endmodule // ctw_bus_master

/* dv/tb_cap_trim_nv_write_and_readback.sv */
// self-checking bench of the capacitor trim command interpreter
`timescale 1ns/1ps
module tb_cap_trim_nv_write_and_readback;
  import ctw_pkg::*;
  localparam logic [5:0] HI   = 6'h15;  // arbitrary value
  localparam logic [8:0] INIT = 9'h1C3;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        scl, sda_low, sda_out, sda_oe, mode_nv, prog_busy, nak;
  logic [8:0]  capacitor_code;
  logic [1:0]  last_nibble_address;
  logic [31:0] w;
  logic        exp_mode;
  logic [8:0]  exp_code;
  logic [7:0]  dat [3] = '{8'hA7, 8'h52, 8'hE1};
  int          fails = 0;
  int          comparisons = 0;
  // pulled up unless someone pulls it low
  wire         sda = ~(sda_oe | sda_low);

  always #2.5 ref_clk = ~ref_clk;

  ctw_cap_trim #(.ADDR_HI(HI), .ADDR_SEL(1'b1), .NV_INIT(INIT))
      ctw_cap_trim_i (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .capacitor_code(capacitor_code),
    .mode_nv(mode_nv), .prog_busy(prog_busy),
    .last_nibble_address(last_nibble_address));

  ctw_bus_master #(.DEV({HI, 1'b1})) ctw_bus_master_i (
    .scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c1, c0);
    ctw_bus_master_i.wcmd(c1, c0, 0, nak);
    chk(nak, 0);
    ctw_bus_master_i.close();
  endtask

  task automatic nvw(input logic [7:0] c1, c0);
    ctw_bus_master_i.wcmd(c1, c0, 2, nak);
    chk(nak, 0);
    chk(prog_busy, 1);
    ctw_bus_master_i.close();
    chk(prog_busy, 0);
    chk(mode_nv, exp_mode);
    chk(capacitor_code, exp_code);
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    ctw_bus_master_i.rd(w, nak);
    chk(nak, 0);
    chk(w, exp);
  endtask

  // reset, then leave the link idle before the first start
  task automatic do_reset();
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    #2.3;
    chk(capacitor_code, INIT);
    chk(mode_nv, 1);
    chk(last_nibble_address, 0);
    chk(sda_out, 0);
    rd_chk(32'h8800_0DC3);
    chk(capacitor_code, INIT);
    exp_mode = 1'b1;
    exp_code = INIT;
  endtask

  initial begin
    do_reset();
    cmd(8'h01, 8'h55);
    exp_mode = 1'b0;
    exp_code = 9'h155;
    chk(mode_nv, exp_mode);
    chk(capacitor_code, exp_code);
    // erase before each nibble write, stored code ends at 0x127
    for (int n = 0; n < 3; n++) begin
      nvw({1'b1, n[1:0], 5'h0F}, 8'hF0);
      nvw({1'b1, n[1:0], 5'h0F}, dat[n]);
    end
    rd_chk(32'h8555_0D27);
    chk(capacitor_code, 9'h155);
    cmd(8'h9A, 8'h3C);
    exp_mode = 1'b1;
    exp_code = 9'h127;
    chk(mode_nv, exp_mode);
    chk(capacitor_code, exp_code);
    rd_chk(32'h8D55_0D27);
    nvw(8'hA0, 8'h00);
    nvw(8'hA0, 8'h09);
    cmd(8'hE0, 8'h0F);
    chk(last_nibble_address, 3);
    // bit 4 set with upper nibble other than 9 is ignored
    cmd(8'hB3, 8'h00);
    chk(last_nibble_address, 3);
    chk(capacitor_code, 9'h127);
    rd_chk(32'h8F55_0D97);
    chk(capacitor_code, 9'h197);
    exp_code = 9'h197;
    nvw(8'h80, 8'h00);
    rd_chk(32'h8955_0D90);
    chk(capacitor_code, 9'h190);
    // ce low hides the stop; the next start drops the pending write
    ctw_bus_master_i.wcmd(8'h80, 8'h05, 0, nak);
    chk(nak, 0);
    @(negedge ref_clk) ce = 1'b0;
    ctw_bus_master_i.close();
    @(negedge ref_clk) ce = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(prog_busy, 1);
    cmd(8'hB3, 8'h00);
    chk(prog_busy, 0);
    rd_chk(32'h8955_0D90);
    // other variant address is not answered
    ctw_bus_master_i.open({HI, 1'b0}, 1'b0, nak);
    chk(nak, 1);
    ctw_bus_master_i.close();
    do_reset();
    results();
  end

  // run needs about 70 us; a hang stops at 400 us
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule // tb_cap_trim_nv_write_and_readback
